// ===== hw/cec_core.sv
// Control and status logic of the block cipher engine
//
// Summary of operation
// - Error flag on control access while busy
// - Error flag on short state block read
// - Done bit shows operation finished
// - Status register is read only
// - Writing start bit one starts operation
// - Mode field: ECB, key, CBC, reserved
// - Direction bit: encrypt or ECB decrypt
// - Control access while busy aborts operation
// - Alias control register at 0x94
// - Done within 24 microseconds of start
// - State range maps key or data
// - Deep sleep resets all registers
`timescale 1ns/1ps

module cec_core
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Host byte access, one cycle per byte
    input wire cec_pkg::cec_access_t host_acc,
    input wire logic host_acc_end,
    output logic [7:0] host_rdata,
    // Transceiver enters deep sleep
    input wire logic deep_sleep,
    // Datapath handshake
    output logic core_start,
    output logic core_abort,
    output cec_pkg::cec_setup_t core_setup,
    input wire logic core_finished,
    output logic core_busy
);

    // ********************************************************
    // Decode
    // ********************************************************
    logic [7:0] control;
    logic busy;
    logic error_flag;
    logic done_flag;
    logic [4:0] read_count;
    logic [10:0] timeout_cnt;
    logic hit_ctrl;
    logic hit_state_rd;
    logic start_req;
    logic clr;

    // Control and its alias behave identically
    assign hit_ctrl = host_acc.valid &&
        (host_acc.addr == cec_pkg::ADDR_CONTROL ||
         host_acc.addr == cec_pkg::ADDR_CONTROL_ALIAS);
    assign hit_state_rd = host_acc.valid && !host_acc.write &&
        host_acc.addr >= cec_pkg::ADDR_STATE_FIRST &&
        host_acc.addr <= cec_pkg::ADDR_STATE_LAST;
    assign start_req = hit_ctrl && host_acc.write && !busy &&
        host_acc.wdata[cec_pkg::BIT_START];
    assign clr = !rst_n || deep_sleep;

    // ********************************************************
    // Control register
    // ********************************************************
    always_ff @(posedge core_clk)
    begin
        if (clr)
            control <= cec_pkg::REG_RESET;
        else if (clk_en && hit_ctrl && host_acc.write)
            control <= {1'b0, host_acc.wdata[6:0] & 7'h78};
    end

    // Busy tracking: start, finish, abort, time limit
    always_ff @(posedge core_clk)
    begin
        if (clr)
            busy <= 1'b0;
        else if (clk_en)
        begin
            if (busy && hit_ctrl)
                busy <= 1'b0;
            else if (busy && (core_finished ||
                     timeout_cnt == 11'(cec_pkg::DONE_MAX_CYC - 2)))
                busy <= 1'b0;
            else if (start_req)
                busy <= 1'b1;
        end
    end

    // Cycle count since start, bounds completion
    always_ff @(posedge core_clk)
    begin
        if (clr)
            timeout_cnt <= '0;
        else if (clk_en)
            timeout_cnt <= busy ? timeout_cnt + 11'h001 : '0;
    end

    // Done flag
    always_ff @(posedge core_clk)
    begin
        if (clr)
            done_flag <= 1'b0;
        else if (clk_en)
        begin
            if (start_req)
                done_flag <= 1'b0;
            else if (busy && !hit_ctrl && (core_finished ||
                     timeout_cnt == 11'(cec_pkg::DONE_MAX_CYC - 2)))
                done_flag <= 1'b1;
        end
    end

    // Read count within one access
    always_ff @(posedge core_clk)
    begin
        if (clr)
            read_count <= '0;
        else if (clk_en)
        begin
            if (host_acc_end)
                read_count <= '0;
            else if (hit_state_rd && read_count != cec_pkg::STATE_BYTES)
                read_count <= read_count + 5'h01;
        end
    end

    // Error flag, sticky until reset or deep sleep; status writes ignored
    always_ff @(posedge core_clk)
    begin
        if (clr)
            error_flag <= 1'b0;
        else if (clk_en)
        begin
            if (busy && hit_ctrl)
                error_flag <= 1'b1;
            else if (host_acc_end && read_count != '0 &&
                     read_count != cec_pkg::STATE_BYTES)
                error_flag <= 1'b1;
        end
    end

    // ********************************************************
    // Read data and outputs
    // ********************************************************
    always_ff @(posedge core_clk)
    begin
        if (clr)
            host_rdata <= cec_pkg::REG_RESET;
        else if (clk_en && host_acc.valid && !host_acc.write)
        begin
            if (host_acc.addr == cec_pkg::ADDR_STATUS)
                host_rdata <= {error_flag, 6'h00, done_flag};
            else if (hit_ctrl)
                host_rdata <= control; // start bit reads zero
            else
                host_rdata <= cec_pkg::REG_RESET;
        end
    end

    // Datapath strobes
    assign core_start = clk_en && start_req;
    assign core_abort = clk_en && busy && hit_ctrl;
    assign core_busy = busy;
    assign core_setup.mode = control[cec_pkg::BIT_MODE_HI:cec_pkg::BIT_MODE_LO];
    assign core_setup.decrypt = control[cec_pkg::BIT_DIR] &&
        control[6:4] == cec_pkg::MODE_ECB;
    assign core_setup.key_select = control[6:4] == cec_pkg::MODE_KEY;

endmodule : cec_core

// ===== hw/cec_pkg.sv
// Package for the cipher engine control and status block
package cec_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] ADDR_STATUS = 8'h82;
    localparam logic [7:0] ADDR_CONTROL = 8'h83;
    localparam logic [7:0] ADDR_STATE_FIRST = 8'h84;
    localparam logic [7:0] ADDR_STATE_LAST = 8'h93;
    localparam logic [7:0] ADDR_CONTROL_ALIAS = 8'h94;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int BIT_ERROR = 7;
    localparam int BIT_DONE = 0;
    localparam int BIT_START = 7;
    localparam int BIT_MODE_HI = 6;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_DIR = 3;

    // Mode encodings
    localparam logic [2:0] MODE_ECB = 3'h0;
    localparam logic [2:0] MODE_KEY = 3'h1;
    localparam logic [2:0] MODE_CBC = 3'h2;

    // Bytes in one state block (128 bits)
    localparam logic [4:0] STATE_BYTES = 5'h10;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_MHZ = 50;
    localparam int DONE_MAX_US = 24;
    localparam int DONE_MAX_CYC = DONE_MAX_US * CLK_MHZ;

    // Host access carrier
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cec_access_t;

    // Settings handed to the datapath
    typedef struct packed {
        logic [2:0] mode;
        logic decrypt;
        logic key_select;
    } cec_setup_t;

endpackage : cec_pkg

// ===== tb/cec_dp_model.sv
// Datapath stand-in that answers a start with a finish pulse
`timescale 1ns/1ps
module cec_dp_model
(
    // Clock and handshake
    input wire logic core_clk,
    input wire logic core_start,
    input wire logic core_abort,
    input wire logic slow,
    output logic core_finished
);
    int cnt = 0;
    // Count down from start; abort cancels, slow never answers
    always_ff @(posedge core_clk)
        cnt <= core_start ? 40 : (core_abort || cnt == 0) ? 0 : cnt - 1;
    assign core_finished = cnt == 1 && !slow;
endmodule : cec_dp_model

// ===== tb/cec_core_props.sv
// Port assertions of the cipher control block
`timescale 1ns/1ps
module cec_core_props
(
    // Watched ports
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire cec_pkg::cec_access_t host_acc,
    input wire logic deep_sleep,
    input wire logic core_start,
    input wire logic core_abort,
    input wire cec_pkg::cec_setup_t core_setup,
    input wire logic core_finished,
    input wire logic core_busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Control or alias access taken this cycle
    wire ctl = host_acc.valid && clk_en && !deep_sleep &&
        (host_acc.addr == 8'h83 || host_acc.addr == 8'h94);
    wire wr = ctl && host_acc.write;
    wire [2:0] wmode = host_acc.wdata[6:4];
    // Enabled cycles spent busy since the operation began
    logic [11:0] busy_cyc;
    always_ff @(posedge core_clk)
        busy_cyc <= (!rst_n || !core_busy) ? 12'h000 :
            busy_cyc + {11'h000, clk_en};
    a_start_on_write:
    assert property (wr && host_acc.wdata[7] && !core_busy |-> core_start)
        else $error("no start");
    a_abort_on_ctl:
    assert property (ctl && core_busy |-> core_abort) else $error("abort");
    a_abort_stops:
    assert property (core_abort |=> !core_busy) else $error("busy stays");
    a_finish_ends:
    assert property (core_finished && core_busy && clk_en |=> !core_busy)
        else $error("no finish");
    a_done_bound:
    assert property (busy_cyc <= 12'h4b0)
        else $error("too slow");
    a_setup_mode:
    assert property (wr && !core_busy |=> core_setup.mode == $past(wmode))
        else $error("mode");
    a_key_map:
    assert property (core_setup.key_select == (core_setup.mode == 3'h1))
        else $error("key map");
    a_sleep_clear:
    assert property (deep_sleep |=> !core_busy) else $error("sleep");
endmodule : cec_core_props
bind cec_core cec_core_props props (.*);

// ===== tb/tb.sv
// Self-checking bench of the cipher control block
`timescale 1ns/1ps
module tb;
    logic core_clk = 0, rst_n = 0, clk_en = 1, host_acc_end = 0;
    logic deep_sleep = 0, slow = 0, core_start, core_abort;
    logic core_finished, core_busy, seen = 0;
    logic [7:0] host_rdata, d, q[$];
    cec_pkg::cec_access_t host_acc = '0;
    cec_pkg::cec_setup_t core_setup;
    int n_mismatch = 0, n_compared = 0;
    always #10 core_clk = ~core_clk;
    cec_core dut (.*);
    cec_dp_model dp (.*);
    task chk(input logic [7:0] got, input logic [7:0] want);
        n_compared++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    task summarize;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task acc(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk);
        host_acc = {1'b1, w, a, v};
        // One byte per access: release after a single edge
        @(negedge core_clk);
        host_acc = '0;
    endtask : acc
    task rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask : rd
    // Idle the bus, then pulse access end or deep sleep
    task pulse(input logic s);
        @(negedge core_clk);
        host_acc = '0;
        deep_sleep = s;
        host_acc_end = !s;
        @(negedge core_clk);
        deep_sleep = 0;
        host_acc_end = 0;
    endtask : pulse
    task idle;
        int i;
        @(negedge core_clk);
        host_acc = '0;
        for (i = 0; i < 1300 && core_busy !== 1'b0; i++)
            @(negedge core_clk);
        if (i == 1300)
        begin
            n_mismatch++;
            summarize();
        end
    endtask : idle
    // Register reads outside the state range note a result
    always @(posedge core_clk)
        seen <= rst_n && host_acc.valid && !host_acc.write &&
            (host_acc.addr < 8'h84 || host_acc.addr > 8'h93);
    always @(negedge core_clk)
        if (seen)
            chk(host_rdata, q.pop_front());
    initial
    begin
        void'($urandom(32'he8e0_5a2f));
        repeat (10) @(negedge core_clk);
        rst_n = 1;
        rd(8'h82, 8'h00);
        rd(8'h83, 8'h00);
        for (int m = 0; m < 8; m++)
        begin
            d = {1'b0, 3'(m), 4'($urandom)};
            acc(1'b1, 8'h83, d);
            rd(8'h83, {d[7:3], 3'h0});
        end
        acc(1'b1, 8'h83, 8'h00);
        acc(1'b1, 8'h94, 8'h80);
        idle();
        rd(8'h82, 8'h01);
        acc(1'b1, 8'h82, 8'hff);
        rd(8'h82, 8'h01);
        slow = 1;
        acc(1'b1, 8'h83, 8'h80);
        rd(8'h82, 8'h00);
        idle();
        rd(8'h82, 8'h01);
        slow = 0;
        acc(1'b1, 8'h94, 8'h80);
        acc(1'b1, 8'h83, 8'h00);
        rd(8'h82, 8'h80);
        pulse(1'b1);
        rd(8'h82, 8'h00);
        for (int a = 8'h84; a < 8'h93; a++)
            acc(1'b0, 8'(a), 8'h00);
        pulse(1'b0);
        rd(8'h82, 8'h80);
        pulse(1'b1);
        for (int a = 8'h84; a <= 8'h93; a++)
            acc(1'b0, 8'(a), 8'h00);
        pulse(1'b0);
        rd(8'h82, 8'h00);
        idle();
        summarize();
    end
endmodule : tb
